// ===== hw/sar_defs.svh
// Constants of the serial readout block: widths and timing counts
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define SAR_RES_W          16
`define SAR_BIT_CNT_W      5
`define SAR_SYNC_STAGES    2

// ****************************************************************
// Timing
// ****************************************************************
`define SAR_CLK_PERIOD_NS  10
`define SAR_CONV_TIME_NS   1300
`define SAR_CONV_CYC       (`SAR_CONV_TIME_NS / `SAR_CLK_PERIOD_NS)
`define SAR_CONV_CNT_W     12

`endif

// ===== hw/sar_pkg.sv
// Types shared by the serial readout block
package sar_pkg;

    // ****************************************************************
    // Interface option latched at each conversion start
    // ****************************************************************
    typedef enum logic [2:0] {
        SAR_IF_3W = 3'b001,
        SAR_IF_4W = 3'b010,
        SAR_IF_DC = 3'b100
    } sar_if_mode_t;

    // ****************************************************************
    // Conversion and readout states
    // ****************************************************************
    typedef enum logic [1:0] {
        SAR_CV_ACQ  = 2'b01,
        SAR_CV_CONV = 2'b10
    } sar_conv_st_t;

    typedef enum logic [2:0] {
        SAR_RD_IDLE  = 3'b001,
        SAR_RD_BUSY  = 3'b010,
        SAR_RD_SHIFT = 3'b100
    } sar_rd_st_t;

    // ****************************************************************
    // Host-facing pins
    // ****************************************************************
    typedef struct packed {
        logic trig;
        logic sclk;
        logic din;
    } sar_pins_t;

endpackage

// ===== hw/sar_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/10ps

module sar_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // ****************************************************************
    // One pair of flops per bit; the first is read only by the second
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                meta_nxt[g] = async_i[g];
                sync_nxt[g] = meta_r[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;

endmodule // sar_sync

// ===== hw/sar_readout_top.sv
// Conversion control and serial readout of the successive-approximation converter
//
// Behaviour
// - 3-wire: trigger line low acts as chip select and starts readout.
// - 4-wire: data input low is chip select; trigger only starts conversions.
// - 3-wire: trigger low enables output and shows MSB before any clock edge.
// - Each falling serial clock edge replaces the output bit with the next lower.
// - 3-wire: output released on trigger high or after last falling clock edge.
// - 4-wire: data input low enables output and shows MSB first.
// - 4-wire: output released on data input high or after last falling edge.
// - Daisy chain: data input shifted in on each falling clock edge.
// - Each option also has a busy-indicator variant with the same timing.
// - Data input level latched at conversion start, with cs_on_trigger_i, selects the next readout option.
// - Low-power state entered at conversion end, held through acquisition.
`timescale 1ns/10ps

`include "sar_defs.svh"

module sar_readout_top
    import sar_pkg::*;
#(
    parameter int RES_W    = `SAR_RES_W,
    parameter int CONV_CYC = `SAR_CONV_CYC
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_i,
    input  wire logic             conversion_trigger_i,
    input  wire logic             sclk_i,
    input  wire logic             din_i,
    input  wire logic             cs_on_trigger_i,
    input  wire logic             busy_ind_en_i,
    input  wire logic [RES_W-1:0] sample_data_i,
    output logic                  dout_o,
    output logic                  dout_oe_o,
    output logic                  power_down_o,
    output logic                  conv_active_o
);

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    sar_pins_t pins_raw;
    sar_pins_t pins_s;

    assign pins_raw = '{trig: conversion_trigger_i, sclk: sclk_i, din: din_i};

    sar_sync #(
        .W (3)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .async_i   (pins_raw),
        .sync_o    (pins_s)
    );

    // Chip select follows the option latched at the last conversion start
    function automatic logic cs_active(input sar_if_mode_t m, input sar_pins_t p);
        if (m == SAR_IF_4W) begin
            cs_active = ~p.din;
        end else begin
            cs_active = ~p.trig;
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    sar_conv_st_t                conv_st_r;
    sar_conv_st_t                conv_st_nxt;
    sar_rd_st_t                  rd_st_r;
    sar_rd_st_t                  rd_st_nxt;
    sar_if_mode_t                mode_r;
    sar_if_mode_t                mode_nxt;
    logic                        busy_var_r;
    logic                        busy_var_nxt;
    logic [`SAR_CONV_CNT_W-1:0]  conv_cnt_r;
    logic [`SAR_CONV_CNT_W-1:0]  conv_cnt_nxt;
    logic [RES_W-1:0]            result_r;
    logic [RES_W-1:0]            result_nxt;
    logic [RES_W-1:0]            shift_r;
    logic [RES_W-1:0]            shift_nxt;
    logic [`SAR_BIT_CNT_W-1:0]   bit_cnt_r;
    logic [`SAR_BIT_CNT_W-1:0]   bit_cnt_nxt;
    logic                        oe_r;
    logic                        oe_nxt;
    logic                        pd_r;
    logic                        pd_nxt;
    logic                        trig_q_r;
    logic                        sclk_q_r;
    logic                        cs_q_r;
    logic                        cs_q_nxt;

    logic                        trig_rise;
    logic                        sclk_fall;
    logic                        cs_now;
    logic                        cs_fall;
    logic                        conv_done;

    // Upper bound of the 16-bit readout counted on falling clock edges
    localparam logic [`SAR_BIT_CNT_W-1:0] LAST_BIT = `SAR_BIT_CNT_W'(RES_W - 1);

    assign trig_rise = pins_s.trig & ~trig_q_r;
    assign sclk_fall = ~pins_s.sclk & sclk_q_r;
    assign conv_done = (conv_st_r == SAR_CV_CONV) && (conv_cnt_r == '0);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        conv_st_nxt  = conv_st_r;
        rd_st_nxt    = rd_st_r;
        mode_nxt     = mode_r;
        busy_var_nxt = busy_var_r;
        conv_cnt_nxt = conv_cnt_r;
        result_nxt   = result_r;
        shift_nxt    = shift_r;
        bit_cnt_nxt  = bit_cnt_r;
        oe_nxt       = oe_r;
        pd_nxt       = pd_r;

        // Mode decided before chip select so a trigger rise sees the new option
        if ((conv_st_r == SAR_CV_ACQ) && trig_rise) begin
            if (pins_s.din && cs_on_trigger_i) begin
                mode_nxt = SAR_IF_3W;
            end else if (pins_s.din) begin
                mode_nxt = SAR_IF_4W;
            end else begin
                mode_nxt = SAR_IF_DC;
            end
            busy_var_nxt = busy_ind_en_i;
        end
        cs_now   = cs_active(mode_nxt, pins_s);
        cs_q_nxt = cs_now;
        cs_fall  = cs_now & ~cs_q_r;

        // Conversion timing; a start during conversion is ignored
        case (conv_st_r)
            SAR_CV_ACQ: begin
                if (trig_rise) begin
                    conv_st_nxt  = SAR_CV_CONV;
                    conv_cnt_nxt = `SAR_CONV_CNT_W'(CONV_CYC - 1);
                    pd_nxt       = 1'b0;
                end
            end
            SAR_CV_CONV: begin
                if (conv_done) begin
                    conv_st_nxt = SAR_CV_ACQ;
                    result_nxt  = sample_data_i;
                    pd_nxt      = 1'b1;
                end else begin
                    conv_cnt_nxt = conv_cnt_r - `SAR_CONV_CNT_W'(1);
                end
            end
            default: begin
                conv_st_nxt = SAR_CV_ACQ;
                pd_nxt      = 1'b1;
            end
        endcase

        // Readout
        case (rd_st_r)
            SAR_RD_IDLE: begin
                if (cs_fall) begin
                    if (conv_st_r == SAR_CV_CONV) begin
                        if (busy_var_r) begin
                            rd_st_nxt = SAR_RD_BUSY;
                            shift_nxt = '0;
                            oe_nxt    = 1'b1;
                        end
                    end else begin
                        rd_st_nxt   = SAR_RD_SHIFT;
                        shift_nxt   = result_r;
                        bit_cnt_nxt = '0;
                        oe_nxt      = 1'b1;
                    end
                end
            end
            SAR_RD_BUSY: begin
                // Output held low while converting, then the MSB appears
                if (conv_done) begin
                    rd_st_nxt   = SAR_RD_SHIFT;
                    shift_nxt   = sample_data_i;
                    bit_cnt_nxt = '0;
                end
            end
            SAR_RD_SHIFT: begin
                if (sclk_fall) begin
                    shift_nxt = {shift_r[RES_W-2:0], (mode_r == SAR_IF_DC) & pins_s.din};
                    if (bit_cnt_r != LAST_BIT) begin
                        bit_cnt_nxt = bit_cnt_r + `SAR_BIT_CNT_W'(1);
                    end else if (mode_r != SAR_IF_DC) begin
                        rd_st_nxt = SAR_RD_IDLE;
                        oe_nxt    = 1'b0;
                    end
                end
            end
            default: begin
                rd_st_nxt = SAR_RD_IDLE;
                oe_nxt    = 1'b0;
            end
        endcase

        // Deselect always wins and releases the output
        if (!cs_now) begin
            rd_st_nxt = SAR_RD_IDLE;
            oe_nxt    = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            conv_st_r  <= SAR_CV_ACQ;
            rd_st_r    <= SAR_RD_IDLE;
            mode_r     <= SAR_IF_3W;
            busy_var_r <= 1'b0;
            conv_cnt_r <= '0;
            result_r   <= '0;
            shift_r    <= '0;
            bit_cnt_r  <= '0;
            oe_r       <= 1'b0;
            pd_r       <= 1'b1;
            trig_q_r   <= 1'b0;
            sclk_q_r   <= 1'b0;
            // Starts selected so a trigger held low over reset is no false select
            cs_q_r     <= 1'b1;
        end else begin
            conv_st_r  <= conv_st_nxt;
            rd_st_r    <= rd_st_nxt;
            mode_r     <= mode_nxt;
            busy_var_r <= busy_var_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            result_r   <= result_nxt;
            shift_r    <= shift_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            oe_r       <= oe_nxt;
            pd_r       <= pd_nxt;
            trig_q_r   <= pins_s.trig;
            sclk_q_r   <= pins_s.sclk;
            cs_q_r     <= cs_q_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Pin sampling adds about three clock cycles of latency to every edge
    assign dout_o        = shift_r[RES_W-1];
    assign dout_oe_o     = oe_r;
    assign power_down_o  = pd_r;
    assign conv_active_o = conv_st_r[1];

endmodule // sar_readout_top

// ===== verification/sar_host_model.sv
// Host controller model driving the converter pins
`timescale 1ns/10ps
module sar_host_model
    import sar_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic dout_i,
    output sar_pins_t pins_o
);
    // Trigger low over reset release, clock idles low
    initial pins_o = '0;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // Eight cycles per level keep pulses and setups far above their minimum
    task automatic set(input logic trig, input logic din);
        pins_o.din  = din;
        pins_o.trig = trig;
        tick(8);
    endtask

    // Sample dout in each high phase, before the next falling edge
    task automatic burst(input int n, input logic dc, input logic [15:0] d,
                         output logic [32:0] s);
        s = '0;
        for (int i = 0; i <= n; i++) begin
            if (dc) pins_o.din = d[15 - (i % 16)];
            pins_o.sclk = (i < n);
            tick(2);
            s = {s[31:0], dout_i};
            tick(2);
            pins_o.sclk = 1'h0;
            tick(4);
        end
    endtask
endmodule // sar_host_model

// ===== verification/sar_readout_properties.sv
// Port assertions of the serial readout block
`timescale 1ns/10ps
module sar_readout_properties
    import sar_pkg::*;
#(
    parameter int RES_W    = 16,
    parameter int CONV_CYC = 130
) (
    input wire logic             clk_sys_i,
    input wire logic             reset_i,
    input wire logic             conversion_trigger_i,
    input wire logic             sclk_i,
    input wire logic             din_i,
    input wire logic             cs_on_trigger_i,
    input wire logic [RES_W-1:0] sample_data_i,
    input wire logic             dout_o,
    input wire logic             dout_oe_o,
    input wire logic             power_down_o,
    input wire logic             conv_active_o
);
    // ********
    // Helpers
    // ********
    sar_pins_t        pin_r, pin_nxt;
    logic             m3_r, m3_nxt, m4_r, m4_nxt;
    logic [RES_W-1:0] res_r, res_nxt;
    logic [7:0]       age_r, age_nxt, fall_r, fall_nxt, conv_r, conv_nxt;

    always_comb begin
        pin_nxt  = '{trig: conversion_trigger_i, sclk: sclk_i, din: din_i};
        m3_nxt   = m3_r;
        m4_nxt   = m4_r;
        if (conversion_trigger_i && !pin_r.trig) begin
            m3_nxt = din_i && cs_on_trigger_i;
            m4_nxt = din_i && !cs_on_trigger_i;
        end
        res_nxt  = conv_active_o ? sample_data_i : res_r;
        age_nxt  = (age_r == 8'hff) ? age_r : age_r + 8'h01;
        if (conv_active_o || pin_nxt != pin_r || reset_i) age_nxt = 8'h00;
        fall_nxt = dout_oe_o ? fall_r + {7'h00, pin_r.sclk & ~sclk_i} : 8'h00;
        conv_nxt = conv_active_o ? conv_r + 8'h01 : 8'h00;
        if (reset_i) begin
            m3_nxt = 1'h0;
            m4_nxt = 1'h0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        pin_r  <= pin_nxt;
        m3_r   <= m3_nxt;
        m4_r   <= m4_nxt;
        res_r  <= res_nxt;
        age_r  <= age_nxt;
        fall_r <= fall_nxt;
        conv_r <= conv_nxt;
    end

    // ********
    // Checks
    // ********
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // Pin edges pass a synchroniser, so answers come a few cycles late
    sequence s_msb_shown;
        ##[2:7] (dout_oe_o && dout_o == res_r[RES_W-1]);
    endsequence

    a_conv_length: assert property (
        $fell(conv_active_o) |-> conv_r == CONV_CYC && power_down_o) else $error("bad conv");
    a_pd_leave: assert property (
        $fell(power_down_o) |-> conv_active_o) else $error("early wake");
    a_trig_release: assert property (
        $rose(conversion_trigger_i) |-> ##[1:7] !dout_oe_o) else $error("no release");
    a_din_release: assert property (
        m4_r && $rose(din_i) |-> ##[1:7] !dout_oe_o) else $error("no release");
    a_msb_three: assert property (
        m3_r && $fell(conversion_trigger_i) && !conv_active_o |-> s_msb_shown)
        else $error("no msb");
    a_msb_four: assert property (
        m4_r && $fell(din_i) && !conv_active_o |-> s_msb_shown) else $error("no msb");
    a_bit_age: assert property (
        $changed(dout_o) && dout_oe_o && $past(dout_oe_o) |-> age_r <= 8'h06)
        else $error("stray bit");
    a_sixteen_falls: assert property (
        (m3_r || m4_r) && fall_r == 8'h10 |-> ##[0:6] !dout_oe_o) else $error("long read");
endmodule // sar_readout_properties

// ===== verification/tb.sv
// Self-checking bench of the serial readout block
`timescale 1ns/10ps
module tb;
    import sar_pkg::*;
    // ********
    // Signals
    // ********
    localparam int CONV = 40;
    logic        clk_sys_i  = 1'h0;
    logic        reset_i    = 1'h1;
    logic        cs_on      = 1'h0;
    logic        busy_en    = 1'h0;
    logic [15:0] sample     = 16'h0000;
    sar_pins_t   pins;
    logic        dout, oe, pd, conv;
    logic        dout_line;
    logic [32:0] s;
    int          n_mismatch = 0;
    int          n_tests    = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    // A released line shows the inverse, so a late or missing enable is caught
    assign dout_line = oe ? dout : ~dout;

    sar_host_model host (.clk_sys_i(clk_sys_i), .dout_i(dout_line), .pins_o(pins));
    sar_readout_top #(.RES_W(16), .CONV_CYC(CONV)) dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .conversion_trigger_i(pins.trig),
        .sclk_i(pins.sclk), .din_i(pins.din), .cs_on_trigger_i(cs_on),
        .busy_ind_en_i(busy_en), .sample_data_i(sample), .dout_o(dout),
        .dout_oe_o(oe), .power_down_o(pd), .conv_active_o(conv));

    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic conv_start(input logic strap, input logic cs, input logic busy,
                              input logic [15:0] data);
        sample  = data;
        cs_on   = cs;
        busy_en = busy;
        host.set(1'h0, strap);
        host.set(1'h1, strap);
        check("start", 2'h2, {conv, pd});
    endtask

    task automatic conv_end();
        host.tick(CONV);
        check("end", 2'h1, {conv, pd});
    endtask

    task automatic test_three_wire();
        conv_start(1'h1, 1'h1, 1'h0, 16'hb38d);
        conv_end();
        host.set(1'h0, 1'h1);
        check("oe", 1'h1, oe);
        host.burst(16, 1'h0, 16'h0000, s);
        check("bits", 16'hb38d, s[16:1]);
        check("oe", 1'h0, oe);
        host.set(1'h1, 1'h1);
        host.tick(CONV);
        $display("three-wire test done");
    endtask

    task automatic test_daisy();
        conv_start(1'h0, 1'h0, 1'h0, 16'h96e2);
        conv_end();
        host.set(1'h0, 1'h0);
        check("oe", 1'h1, oe);
        host.burst(32, 1'h1, 16'h3c5a, s);
        check("chain", 32'h96e23c5a, s[32:1]);
        check("oe", 1'h1, oe);
        host.set(1'h1, 1'h0);
        check("oe", 1'h0, oe);
        host.tick(CONV);
        $display("daisy test done");
    endtask

    task automatic test_four_wire_busy();
        conv_start(1'h1, 1'h0, 1'h1, 16'h4e71);
        host.set(1'h1, 1'h0);
        check("busy", 2'h2, {oe, dout});
        conv_end();
        host.burst(8, 1'h0, 16'h0000, s);
        check("bits", 8'h4e, s[8:1]);
        host.set(1'h1, 1'h1);
        check("oe", 1'h0, oe);
        $display("four-wire test done");
    endtask

    // Select during conversion is refused without the busy variant
    task automatic test_four_wire();
        conv_start(1'h1, 1'h0, 1'h0, 16'h61d9);
        host.set(1'h1, 1'h0);
        check("oe", 1'h0, oe);
        conv_end();
        host.set(1'h1, 1'h1);
        host.set(1'h1, 1'h0);
        check("oe", 1'h1, oe);
        host.burst(16, 1'h0, 16'h0000, s);
        check("bits", 16'h61d9, s[16:1]);
        check("oe", 1'h0, oe);
        host.set(1'h1, 1'h1);
        $display("four-wire plain test done");
    endtask

    initial begin
        host.tick(4);
        reset_i = 1'h0;
        host.tick(4);
        test_three_wire();
        test_daisy();
        test_four_wire_busy();
        test_four_wire();
        report_and_stop();
    end

    // Twice the expected run time, so only a hang reaches it
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // tb

bind sar_readout_top sar_readout_properties #(.RES_W(RES_W), .CONV_CYC(CONV_CYC)) u_props (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .conversion_trigger_i(conversion_trigger_i),
    .sclk_i(sclk_i), .din_i(din_i), .cs_on_trigger_i(cs_on_trigger_i),
    .sample_data_i(sample_data_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .power_down_o(power_down_o), .conv_active_o(conv_active_o));
